// *** psw_defs.vh ***
`ifndef PSW_DEFS_VH
`define PSW_DEFS_VH
// Register word offsets (byte addresses)
`define PSW_CTRL_OFS 4'h0
`define PSW_STAT_OFS 4'h4
// Control fields
`define PSW_CTRL_FORCE_BAT 0
`define PSW_CTRL_RST 32'h0000_0000
// Status fields
`define PSW_STAT_STATE_LSB 0
`define PSW_STAT_LATCH 8
`define PSW_STAT_POR 9
`define PSW_STAT_WDR 10
`define PSW_STAT_ADP 11
// Timing
`define PSW_CLK_MHZ 100
`define PSW_POR_MS 800
`define PSW_WDR_MS 10
`define PSW_WDT_MS 60
`define PSW_POR_CYC (`PSW_POR_MS * `PSW_CLK_MHZ * 1000)
`define PSW_WDR_CYC (`PSW_WDR_MS * `PSW_CLK_MHZ * 1000)
`define PSW_WDT_CYC (`PSW_WDT_MS * `PSW_CLK_MHZ * 1000)
`endif

// *** psw_top.v ***
`timescale 1ns/1ns
`include "psw_defs.vh"

module psw_top #(
  parameter [26:0] POR_CYC = `PSW_POR_CYC, // Power-on reset hold
  parameter [26:0] WDR_CYC = `PSW_WDR_CYC, // Watchdog reset hold
  parameter [26:0] WDT_CYC = `PSW_WDT_CYC // Kick interval limit
) (
  input wire clk_i, // System clock
  input wire rst_i, // Synchronous reset
  // Wishbone slave
  input wire cyc_i, // Bus cycle
  input wire stb_i, // Strobe
  input wire we_i, // Write enable
  input wire [3:0] adr_i, // Byte address
  input wire [3:0] sel_i, // Byte selects
  input wire [31:0] dat_i, // Write data
  output reg [31:0] dat_o, // Read data
  output reg ack_o, // Acknowledge
  // Supply sense
  input wire adapter_valid_i, // Adapter above lockout
  input wire adapter_present_i, // Adapter connected
  input wire battery_present_i, // Battery connected
  input wire battery_valid_i, // Battery above lockout
  input wire system_rail_good_i, // System rail at 90%
  input wire always_on_good_i, // Always-on group at 90%
  input wire switched_good_i, // Switched group at 90%
  // Host pins
  input wire system_wake_n_i, // Push-button wake
  input wire always_on_rail_enable_n_i, // Always-on enable
  input wire switched_rail_enable_i, // Switched enable
  input wire battery_feed_select_i, // Battery feed select
  input wire watchdog_kick_i, // Watchdog kick
  // Power controls
  output reg adapter_feed_o, // Adapter regulator on
  output reg battery_feed_o, // Battery switch closed
  output reg always_on_group_en_o, // Always-on group enable
  output reg switched_group_en_o, // Switched group enable
  output reg discharge_o, // Output pull-downs on
  output reg charger_en_o, // Charger enable
  output reg charge_state_n_o, // Charge status pin
  output reg power_on_reset_n_o, // Power-on reset
  output reg watchdog_reset_n_o // Watchdog reset
);

  // One-hot sequencer states
  localparam [5:0] ST_OFF = 6'b00_0001;
  localparam [5:0] ST_SYS = 6'b00_0010;
  localparam [5:0] ST_AON = 6'b00_0100;
  localparam [5:0] ST_POR = 6'b00_1000;
  localparam [5:0] ST_RUN = 6'b01_0000;
  localparam [5:0] ST_SHUT = 6'b10_0000;

  reg [5:0] state;
  reg [5:0] next_state;
  reg [26:0] por_cnt;
  reg [26:0] next_por_cnt;
  reg [26:0] wd_cnt;
  reg wd_live;
  reg wake_latch;
  reg force_bat;
  reg adp_present_q;

  // Previous synchronised kick level, for edge detection
  reg kick_q;

  wire wake_n_s;
  wire aon_en_n_s;
  wire sw_en_s;
  wire feed_sel_s;
  wire kick_s;
  wire kick_edge;
  wire powered;
  wire supply_any;
  wire adp_removed;
  wire start_req;
  wire bat_only_off;
  wire wb_req;
  wire [31:0] stat_word;

  // Synchronised host pins; each resets to its idle level

  // Wake button, idle high
  psw_sync #(
    .RST_VAL(1'b1)
  ) i_sync_wake (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(system_wake_n_i),
    .q_o(wake_n_s)
  );

  // Always-on enable, active low
  psw_sync #(
    .RST_VAL(1'b1)
  ) i_sync_aon (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(always_on_rail_enable_n_i),
    .q_o(aon_en_n_s)
  );

  // Switched group enable
  psw_sync #(
    .RST_VAL(1'b0)
  ) i_sync_sw (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(switched_rail_enable_i),
    .q_o(sw_en_s)
  );

  // Battery feed select
  psw_sync #(
    .RST_VAL(1'b0)
  ) i_sync_feed (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(battery_feed_select_i),
    .q_o(feed_sel_s)
  );

  // Watchdog kick
  psw_sync #(
    .RST_VAL(1'b0)
  ) i_sync_kick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(watchdog_kick_i),
    .q_o(kick_s)
  );

  // Delayed kick; reads only the second synchroniser stage
  always @(posedge clk_i) begin
    if (rst_i) begin
      kick_q <= 1'b0;
    end else begin
      kick_q <= kick_s;
    end
  end

  // Both kick edges count
  assign kick_edge = kick_s ^ kick_q;

  // Supply conditions
  assign supply_any = adapter_present_i | battery_present_i;
  assign adp_removed = adp_present_q & ~adapter_present_i;
  assign powered = ~state[0] & ~state[5];

  // Start on button without adapter, or on valid adapter
  assign start_req = (~wake_n_s & ~adapter_valid_i)
                     | adapter_valid_i;

  // Battery-only shutdown: enable low with button pressed
  assign bat_only_off = ~adapter_valid_i & battery_valid_i
                        & ~aon_en_n_s & ~wake_n_s;

  // Wake latch holds while any supply is connected
  always @(posedge clk_i) begin
    if (rst_i) begin
      wake_latch <= 1'b0;
      adp_present_q <= 1'b0;
    end else begin
      adp_present_q <= adapter_present_i;
      if (~wake_n_s & supply_any)
        wake_latch <= 1'b1;
      else if (~supply_any)
        wake_latch <= 1'b0;
    end
  end

  // Sequencer next-state logic
  always @* begin
    next_state = state;
    next_por_cnt = por_cnt;
    case (state)
      ST_OFF: begin
        next_por_cnt = 27'd0;
        if (start_req & supply_any)
          next_state = ST_SYS;
      end
      ST_SYS: begin
        // Rail first, groups wait for it
        if (system_rail_good_i)
          next_state = ST_AON;
      end
      ST_AON: begin
        if (always_on_good_i) begin
          next_state = ST_POR;
          next_por_cnt = 27'd0;
        end
      end
      ST_POR: begin
        if (por_cnt >= POR_CYC - 27'd1)
          next_state = ST_RUN;
        else
          next_por_cnt = por_cnt + 27'd1;
      end
      ST_RUN: begin
        next_state = ST_RUN;
      end
      ST_SHUT: begin
        next_state = ST_OFF;
      end
      default: begin
        next_state = ST_OFF;
      end
    endcase
    // Power-down decisions apply once up
    if (powered) begin
      if (adapter_valid_i) begin
        // No power down while adapter is valid
        next_state = next_state;
      end else if (adp_removed & ~wake_latch) begin
        next_state = ST_SHUT;
      end else if (adapter_present_i) begin
        // Below lockout but still connected: stay up
        next_state = next_state;
      end else if (bat_only_off & state[4]) begin
        next_state = ST_SHUT;
      end else if (~supply_any) begin
        next_state = ST_SHUT;
      end
    end
  end

  // Sequencer registers
  always @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_OFF;
      por_cnt <= 27'd0;
    end else begin
      state <= next_state;
      por_cnt <= next_por_cnt;
    end
  end

  // Watchdog reset timer and kick monitor
  always @(posedge clk_i) begin
    if (rst_i) begin
      wd_cnt <= 27'd0;
      wd_live <= 1'b0;
    end else if (~state[4]) begin
      wd_cnt <= 27'd0;
      wd_live <= 1'b0;
    end else if (~wd_live) begin
      // Held in reset: count release time only
      if (~switched_good_i) begin
        wd_cnt <= 27'd0;
      end else if (wd_cnt >= WDR_CYC - 27'd1) begin
        wd_live <= 1'b1;
        wd_cnt <= 27'd0;
      end else begin
        wd_cnt <= wd_cnt + 27'd1;
      end
    end else if (kick_edge) begin
      wd_cnt <= 27'd0;
    end else if (wd_cnt >= WDT_CYC - 27'd1) begin
      // Kick gap too long: assert reset again
      wd_live <= 1'b0;
      wd_cnt <= 27'd0;
    end else begin
      wd_cnt <= wd_cnt + 27'd1;
    end
  end

  // Rail and group controls, all registered
  always @(posedge clk_i) begin
    if (rst_i) begin
      adapter_feed_o <= 1'b0;
      battery_feed_o <= 1'b0;
      always_on_group_en_o <= 1'b0;
      switched_group_en_o <= 1'b0;
      discharge_o <= 1'b1;
      charger_en_o <= 1'b0;
      charge_state_n_o <= 1'b0;
      power_on_reset_n_o <= 1'b0;
      watchdog_reset_n_o <= 1'b0;
    end else begin
      // Source select for the system rail
      if (~powered) begin
        adapter_feed_o <= 1'b0;
        battery_feed_o <= 1'b0;
      end else if (adapter_valid_i & ~feed_sel_s & ~force_bat) begin
        adapter_feed_o <= 1'b1;
        battery_feed_o <= 1'b0;
      end else if (adapter_valid_i) begin
        adapter_feed_o <= 1'b0;
        battery_feed_o <= 1'b1;
      end else begin
        adapter_feed_o <= 1'b0;
        battery_feed_o <= 1'b1;
      end
      // Always-on group after rail good, gated by its enable
      always_on_group_en_o <= (state[2] | state[3] | state[4])
                              & ~aon_en_n_s;
      // Switched group no earlier than reset release, on the same edge at the soonest
      switched_group_en_o <= state[4] & sw_en_s;
      // Pull-downs while not powered
      discharge_o <= ~powered | state[5];
      // Charger follows adapter valid
      charger_en_o <= adapter_valid_i;
      charge_state_n_o <= adapter_valid_i;
      power_on_reset_n_o <= state[4];
      watchdog_reset_n_o <= wd_live;
    end
  end

  // Status word for software
  assign stat_word = {20'h0_0000, adapter_valid_i, wd_live,
                      state[4], wake_latch, 2'b00, state};

  assign wb_req = cyc_i & stb_i & ~ack_o;

  // Wishbone slave: one wait state, unmapped reads zero
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
      force_bat <= 1'b0;
    end else begin
      ack_o <= wb_req;
      dat_o <= 32'h0000_0000;
      if (wb_req) begin
        case (adr_i)
          `PSW_CTRL_OFS: begin
            dat_o <= {31'h0000_0000, force_bat};
            if (we_i & sel_i[0])
              force_bat <= dat_i[`PSW_CTRL_FORCE_BAT];
          end
          `PSW_STAT_OFS: begin
            dat_o <= stat_word;
          end
          default: begin
            dat_o <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

endmodule // psw_top

// Two-flop synchroniser for one host pin
module psw_sync #(
  parameter [0:0] RST_VAL = 1'b0 // Level held during reset
) (
  input wire clk_i, // System clock
  input wire rst_i, // Synchronous reset
  input wire d_i, // Raw pin level
  output reg q_o // Synchronised level
);

  // First stage may go metastable; nothing outside reads it
  reg meta;

  // Reset to the idle level so no false edge follows reset
  always @(posedge clk_i) begin
    if (rst_i) begin
      meta <= RST_VAL;
      q_o <= RST_VAL;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end

endmodule // psw_sync

// *** psw_top_props.sv ***
`timescale 1ns/1ns
module psw_top_props #(
  parameter [26:0] POR_CYC = 200, // Power-on reset hold
  parameter [26:0] WDR_CYC = 50, // Watchdog reset hold
  parameter [26:0] WDT_CYC = 100 // Kick interval limit
) (
  input wire clk_i, // Clock
  input wire rst_i, // Reset
  input wire cyc_i, // Bus cycle
  input wire stb_i, // Strobe
  input wire ack_o, // Acknowledge
  input wire adapter_valid_i, // Adapter valid
  input wire adapter_present_i, // Adapter connected
  input wire always_on_good_i, // Always-on good
  input wire switched_good_i, // Switched good
  input wire watchdog_kick_i, // Kick
  input wire adapter_feed_o, // Adapter feed
  input wire battery_feed_o, // Battery feed
  input wire switched_group_en_o, // Switched enable
  input wire charger_en_o, // Charger on
  input wire charge_state_n_o, // Charge status
  input wire power_on_reset_n_o, // Power-on reset
  input wire watchdog_reset_n_o // Watchdog reset
);
  reg [31:0] lo_cnt, wd_cnt, kc;
  reg kq;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Cycles in reset with the cause of the reset timer present; kc counts kick-free cycles once released
  always @(posedge clk_i) begin
    kq <= watchdog_kick_i;
    if (rst_i || power_on_reset_n_o || !always_on_good_i)
      lo_cnt <= 0;
    else
      lo_cnt <= lo_cnt + 1;
    if (rst_i || watchdog_reset_n_o || !switched_good_i || !power_on_reset_n_o)
      wd_cnt <= 0;
    else
      wd_cnt <= wd_cnt + 1;
    if (rst_i || !watchdog_reset_n_o || watchdog_kick_i != kq)
      kc <= 0;
    else
      kc <= kc + 1;
  end
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack held too long");
  a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack missing");
  a_chg_follow: assert property (!$past(rst_i) |->
    charger_en_o == $past(adapter_valid_i)) else $error("charger lag");
  a_chg_status: assert property (charge_state_n_o == charger_en_o)
    else $error("status pin wrong");
  a_switched_after: assert property (switched_group_en_o |->
    power_on_reset_n_o) else $error("switched group early");
  a_por_hold: assert property ($rose(power_on_reset_n_o) |->
    lo_cnt >= POR_CYC && lo_cnt <= POR_CYC + 8) else $error("por span");
  a_wdr_hold: assert property ($rose(watchdog_reset_n_o) |->
    wd_cnt >= WDR_CYC && wd_cnt <= WDR_CYC + 8) else $error("wdr span");
  a_wdt_fire: assert property ($fell(watchdog_reset_n_o) &&
    power_on_reset_n_o |-> kc >= WDT_CYC && kc <= WDT_CYC + 8)
    else $error("watchdog span");
  a_feed_one: assert property (!(adapter_feed_o && battery_feed_o))
    else $error("both feeds on");
  a_no_down: assert property (power_on_reset_n_o && adapter_valid_i &&
    adapter_present_i |=> power_on_reset_n_o) else $error("powered down");
endmodule // psw_top_props
bind psw_top psw_top_props #(.POR_CYC(POR_CYC), .WDR_CYC(WDR_CYC),
  .WDT_CYC(WDT_CYC)) i_psw_top_props (.clk_i, .rst_i, .cyc_i, .stb_i,
  .ack_o, .adapter_valid_i, .adapter_present_i, .always_on_good_i,
  .switched_good_i, .watchdog_kick_i, .adapter_feed_o, .battery_feed_o,
  .switched_group_en_o, .charger_en_o, .charge_state_n_o,
  .power_on_reset_n_o, .watchdog_reset_n_o);

// *** psw_host.sv ***
`timescale 1ns/1ns
module psw_host (
  input wire clk_i, // Clock
  input wire run_i, // Watchdog released, host alive
  input wire por_n_i, // Power-on reset seen
  output reg kick_o, // Watchdog kick
  output reg sw_en_o // Switched enable
);
  reg [4:0] gap;
  initial begin
    kick_o = 1'b0;
    sw_en_o = 1'b0;
    gap = 5'h00;
  end
  // Kick every 30 cycles; switched enable only after reset release
  always @(posedge clk_i) begin
    sw_en_o <= por_n_i;
    if (!run_i)
      gap <= 5'h00;
    else if (gap == 5'h1d) begin
      gap <= 5'h00;
      kick_o <= ~kick_o;
    end else
      gap <= gap + 5'h01;
  end
endmodule // psw_host

// *** psw_top_bench.sv ***
`timescale 1ns/1ns
module psw_top_bench;
  reg clk_i, rst_i, cyc_i, stb_i, we_i, adapter_valid_i, adapter_present_i;
  reg battery_present_i, system_rail_good_i, always_on_good_i, stall;
  reg switched_good_i, system_wake_n_i, always_on_rail_enable_n_i;
  reg battery_feed_select_i, battery_valid_i;
  reg [3:0] adr_i;
  reg [31:0] dat_i, q;
  reg [4:0] r;
  reg [4:0] rows [0:4];
  wire [31:0] dat_o;
  wire ack_o, adapter_feed_o, battery_feed_o, always_on_group_en_o;
  wire switched_group_en_o, charger_en_o, charge_state_n_o, discharge_o;
  wire power_on_reset_n_o, watchdog_reset_n_o, watchdog_kick_i;
  wire switched_rail_enable_i;
  integer err_total, comparisons, i;
  psw_top #(.POR_CYC(27'h00c8), .WDR_CYC(27'h0032), .WDT_CYC(27'h0064))
    i_psw_top (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
    .sel_i(4'hf), .dat_i, .dat_o, .ack_o, .adapter_valid_i,
    .adapter_present_i, .battery_present_i, .battery_valid_i,
    .system_rail_good_i, .always_on_good_i, .switched_good_i,
    .system_wake_n_i, .always_on_rail_enable_n_i, .switched_rail_enable_i,
    .battery_feed_select_i, .watchdog_kick_i, .adapter_feed_o,
    .battery_feed_o, .always_on_group_en_o, .switched_group_en_o,
    .discharge_o, .charger_en_o, .charge_state_n_o, .power_on_reset_n_o,
    .watchdog_reset_n_o);
  psw_host i_psw_host (.clk_i, .run_i(watchdog_reset_n_o & ~stall),
    .por_n_i(power_on_reset_n_o), .kick_o(watchdog_kick_i),
    .sw_en_o(switched_rail_enable_i));
  initial clk_i = 1'b0;
  always #5 clk_i = ~clk_i;
  // Rails reach their good level one cycle after being switched on
  always @(posedge clk_i) begin
    system_rail_good_i <= adapter_feed_o | battery_feed_o;
    always_on_good_i <= always_on_group_en_o;
    switched_good_i <= switched_group_en_o;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("ERROR t=%0t seen %h exp %h", $time, seen, exp);
      end
    end
  endtask
  task step(input integer n);
    begin
      repeat (n) @(posedge clk_i);
      #1;
    end
  endtask
  // One classic cycle; waits for ack at a rising edge
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    integer n;
    begin
      n = 0;
      @(posedge clk_i);
      {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
      do begin
        @(posedge clk_i);
        n = n + 1;
      end while (ack_o !== 1'b1 && n < 20);
      q = dat_o;
      {cyc_i, stb_i, we_i} <= 3'h0;
      chk(n < 20, 1'b1);
    end
  endtask
  // Bounded wait: 0 reset, 1 watchdog, 2 discharge, 3 battery feed
  task wait_sig(input integer s, input logic v, input integer lim);
    integer n;
    logic x;
    begin
      n = 0;
      do begin
        step(1);
        n = n + 1;
        case (s)
          0: x = power_on_reset_n_o;
          1: x = watchdog_reset_n_o;
          2: x = discharge_o;
          default: x = battery_feed_o;
        endcase
      end while (x !== v && n < lim);
      chk(x, v);
    end
  endtask
  task complete_run;
    begin
      $display("comparisons %0d errors %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  // The sequence needs under 3000 cycles
  initial begin
    #300000;
    err_total = err_total + 1;
    complete_run;
  end
  initial begin
    {cyc_i, stb_i, we_i, adapter_valid_i, adapter_present_i, stall} = 0;
    {adr_i, dat_i, battery_feed_select_i, always_on_rail_enable_n_i} = 0;
    {system_rail_good_i, always_on_good_i, switched_good_i} = 0;
    battery_present_i = 1'b1;
    battery_valid_i = 1'b1;
    system_wake_n_i = 1'b1;
    err_total = 0;
    comparisons = 0;
    // Rows: adapter valid, feed select, force, adapter feed, battery feed
    rows[0] = 5'h12;
    rows[1] = 5'h19;
    rows[2] = 5'h15;
    rows[3] = 5'h01;
    rows[4] = 5'h12;
    rst_i = 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    step(1);
    chk(discharge_o, 1'b1);
    chk(power_on_reset_n_o, 1'b0);
    $display("reset test done");
    @(posedge clk_i);
    {adapter_present_i, adapter_valid_i} <= 2'h3;
    wait_sig(0, 1'b1, 400);
    chk(discharge_o, 1'b0);
    wait_sig(1, 1'b1, 200);
    for (i = 0; i < 5; i = i + 1) begin
      r = rows[i];
      @(posedge clk_i);
      {adapter_valid_i, battery_feed_select_i} <= r[4:3];
      bus(1'b1, 4'h0, {31'h0000_0000, r[2]});
      step(8);
      chk(adapter_feed_o, r[1]);
      chk(battery_feed_o, r[0]);
      chk(charge_state_n_o, r[4]);
      chk(power_on_reset_n_o, 1'b1);
      bus(1'b0, 4'h0, 32'h0000_0000);
      chk(q, {31'h0000_0000, r[2]});
      $display("row %0d done", i);
    end
    @(posedge clk_i);
    stall <= 1'b1;
    wait_sig(1, 1'b0, 140);
    @(posedge clk_i);
    stall <= 1'b0;
    wait_sig(1, 1'b1, 100);
    bus(1'b1, 4'h8, 32'h0000_0001);
    bus(1'b0, 4'h8, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    bus(1'b0, 4'h4, 32'h0000_0000);
    chk(q[11:8], 4'he);
    $display("watchdog and status test done");
    @(posedge clk_i);
    always_on_rail_enable_n_i <= 1'b1;
    step(8);
    chk(always_on_group_en_o, 1'b0);
    chk(power_on_reset_n_o, 1'b1);
    @(posedge clk_i);
    always_on_rail_enable_n_i <= 1'b0;
    {adapter_present_i, adapter_valid_i} <= 2'h0;
    wait_sig(2, 1'b1, 20);
    chk(always_on_group_en_o, 1'b0);
    $display("adapter removal test done");
    @(posedge clk_i);
    system_wake_n_i <= 1'b0;
    step(4);
    @(posedge clk_i);
    system_wake_n_i <= 1'b1;
    wait_sig(3, 1'b1, 20);
    chk(always_on_group_en_o, 1'b0);
    wait_sig(0, 1'b1, 400);
    @(posedge clk_i);
    {adapter_present_i, adapter_valid_i} <= 2'h3;
    step(10);
    @(posedge clk_i);
    {adapter_present_i, adapter_valid_i} <= 2'h0;
    step(20);
    chk(power_on_reset_n_o, 1'b1);
    @(posedge clk_i);
    system_wake_n_i <= 1'b0;
    wait_sig(2, 1'b1, 20);
    chk(switched_group_en_o, 1'b0);
    $display("push button test done");
    complete_run;
  end
endmodule // psw_top_bench
